// file: emg_consts.vh
// Constants for the error measurement gating block.
// Assumes a single 50 MHz system clock and no register bus.
`ifndef EMG_CONSTS_VH
`define EMG_CONSTS_VH

// Clock period and derived time bases.
`define EMG_CLK_NS 20
`define EMG_T_MS_NS 1000000
`define EMG_MS_PER_S 10'd1000

// Counter widths; E+16 needs 54 bits.
`define EMG_CW 56
`define EMG_IW 32

// Gating units.
`define EMG_U_TIME 2'h0
`define EMG_U_CLK 2'h1
`define EMG_U_ERR 2'h2
`define EMG_U_BLK 2'h3

// Cycle modes.
`define EMG_C_REPEAT 2'h0
`define EMG_C_SINGLE 2'h1
`define EMG_C_UNTIMED 2'h2

// Interim update interval selections and lengths in ms.
`define EMG_UPD_100 2'h0
`define EMG_UPD_200 2'h1
`define EMG_UPD_500 2'h2
`define EMG_UPD_100_MS 10'd100
`define EMG_UPD_200_MS 10'd200
`define EMG_UPD_500_MS 10'd500

// Interval selections for errored / error-free intervals, lengths in ms.
`define EMG_I_1MS 2'h0
`define EMG_I_10MS 2'h1
`define EMG_I_100MS 2'h2
`define EMG_I_1S 2'h3
`define EMG_I_1_MS 10'd1
`define EMG_I_10_MS 10'd10
`define EMG_I_100_MS 10'd100

// Target exponent limits.
`define EMG_EXP_MIN 5'h04
`define EMG_EXP_MAX 5'h10
`define EMG_BEXP_MIN 5'h02
`define EMG_BEXP_MAX 5'h0e

// Period limits in seconds: 1 s to 99 d 23:59:59.
`define EMG_PER_MIN 24'h000001
`define EMG_PER_MAX 24'h83d5ff

// Bit window: 32-bit segments, 16 of them over a 512-bit pattern.
`define EMG_SEG_LSB 5
`define EMG_POS_MSB 8
`define EMG_SEGS 16

`endif

// file: emg_gating.v
// Measurement gating for a bit-error detector: counts, periods, interim results.
// Assumes bit strobes, expected bits and pattern position arrive synchronous
// to i_clk_sys; all controls are plain ports with no register bus.
`timescale 1ns/1ps
`include "emg_consts.vh"

module emg_gating #(
   parameter MS_CYCLES = `EMG_T_MS_NS / `EMG_CLK_NS
) (
   input wire i_clk_sys, // System clock, 50 MHz.
   input wire i_rst_n, // Asynchronous reset, active low.
   input wire i_start, // Start measurement pulse.
   input wire i_stop, // Stop measurement pulse.
   input wire [1:0] i_unit, // Gating unit.
   input wire [1:0] i_cycle, // Cycle mode.
   input wire [23:0] i_period_s, // Period in seconds.
   input wire [4:0] i_target_exp, // Target power of ten.
   input wire i_current_on, // Interim results enabled.
   input wire i_calc_immediate, // Immediate rather than progressive.
   input wire [1:0] i_upd_sel, // Interim update interval.
   input wire i_combo, // Two-channel combination active.
   input wire i_detect_trans, // Transition detection requested.
   input wire [1:0] i_intv_sel, // Interval length select.
   input wire i_bit_vld, // Received bit strobe.
   input wire i_rx_bit, // Received bit.
   input wire i_exp_bit, // Expected bit.
   input wire [8:0] i_pat_pos, // Bit position within pattern.
   input wire i_mask_bit, // Block mask value of this bit.
   input wire i_block_done, // One pattern block executed.
   input wire i_blk_win_set, // Request to change block masking.
   input wire i_blk_win_val, // Requested block masking state.
   input wire i_pat_prbs_mixed, // Pattern is PRBS or mixed.
   input wire i_capturing, // Data capture started.
   input wire i_bit_win_en, // Bit window enable.
   input wire [15:0] i_bit_win_map, // Enable per 32-bit segment.
   output reg o_running, // Measurement in progress.
   output reg o_period_done, // Period complete pulse.
   output reg o_result_vld, // Published results pulse.
   output reg [55:0] o_err_total, // Total errors.
   output reg [55:0] o_err_a, // Insertion or transition errors.
   output reg [55:0] o_err_b, // Omission or non-transition errors.
   output reg [55:0] o_clk_cnt, // Clock (bit) count.
   output reg [55:0] o_blk_cnt, // Block count.
   output reg [31:0] o_errored_interval_count, // Errored intervals.
   output reg [31:0] o_error_free_interval_count, // Error-free intervals.
   output reg o_blk_win_en, // Block masking state.
   output reg o_blk_win_refused, // Mask change refused pulse.
   output reg o_trans_mode // Transition detection in force.
);

   // Power of ten as a counter-width value.
   function [55:0] pow10;
      input [4:0] e;
      integer k;
      reg [55:0] v;
      begin
         v = 56'h1;
         for (k = 0; k <= `EMG_EXP_MAX; k = k + 1) begin
            if (k < e) begin
               v = v * 56'ha;
            end
         end
         pow10 = v;
      end
   endfunction

   reg [31:0] ms_div_r;
   reg ms_tick_r;
   reg [9:0] ms_in_s_r;
   reg sec_tick_r;
   reg [9:0] upd_ms_r;
   reg [9:0] intv_ms_r;
   reg intv_err_r;
   reg [23:0] sec_cnt_r;
   reg [55:0] cnt_a_r;
   reg [55:0] cnt_b_r;
   reg [55:0] cnt_clk_r;
   reg [55:0] cnt_blk_r;
   reg [31:0] ei_r;
   reg [31:0] efi_r;
   reg [55:0] snap_a_r;
   reg [55:0] snap_b_r;
   reg [55:0] snap_clk_r;
   reg [55:0] snap_blk_r;
   reg prev_exp_r;

   wire [31:0] ms_last = MS_CYCLES - 1;
   wire [9:0] upd_len;
   wire [9:0] intv_len;
   wire [4:0] exp_c;
   wire [55:0] target;
   wire [23:0] period_c;
   wire hit;
   wire period_end;
   wire bit_win_ok;
   wire meas_bit;
   wire err_bit;
   wire trans_sel;
   wire ev_a;
   wire ev_b;
   wire upd_tick;
   wire intv_end;
   wire err_now;

   // A 500 ms choice outside combination falls back to 200 ms.
   assign upd_len = (i_upd_sel == `EMG_UPD_100) ? `EMG_UPD_100_MS :
      (i_upd_sel == `EMG_UPD_500 && i_combo) ? `EMG_UPD_500_MS :
      `EMG_UPD_200_MS;

   // Interval length; the one-second setting uses a whole second.
   assign intv_len = (i_intv_sel == `EMG_I_1MS) ? `EMG_I_1_MS :
      (i_intv_sel == `EMG_I_10MS) ? `EMG_I_10_MS :
      (i_intv_sel == `EMG_I_100MS) ? `EMG_I_100_MS :
      `EMG_MS_PER_S;

   // Clamp the exponent into the range of the selected unit.
   assign exp_c = (i_unit == `EMG_U_BLK) ?
      ((i_target_exp < `EMG_BEXP_MIN) ? `EMG_BEXP_MIN :
      (i_target_exp > `EMG_BEXP_MAX) ? `EMG_BEXP_MAX : i_target_exp) :
      ((i_target_exp < `EMG_EXP_MIN) ? `EMG_EXP_MIN :
      (i_target_exp > `EMG_EXP_MAX) ? `EMG_EXP_MAX : i_target_exp);
   assign target = pow10(exp_c);

   // Clamp the period so an out-of-range setting still ends.
   assign period_c = (i_period_s < `EMG_PER_MIN) ? `EMG_PER_MIN :
      (i_period_s > `EMG_PER_MAX) ? `EMG_PER_MAX : i_period_s;

   // Count targets are checked only at the close of each second.
   assign hit = (i_unit == `EMG_U_TIME) ? (sec_cnt_r + 24'h1 >= period_c) :
      (i_unit == `EMG_U_CLK) ? (cnt_clk_r >= target) :
      (i_unit == `EMG_U_ERR) ? (cnt_a_r + cnt_b_r >= target) :
      (cnt_blk_r >= target);
   assign period_end = o_running && sec_tick_r && hit &&
      (i_cycle != `EMG_C_UNTIMED);

   // Per-bit qualification by block mask and bit window.
   assign bit_win_ok = !i_bit_win_en ||
      i_bit_win_map[i_pat_pos[`EMG_POS_MSB:`EMG_SEG_LSB]];
   assign meas_bit = o_running && i_bit_vld && bit_win_ok &&
      !(o_blk_win_en && i_mask_bit);
   assign err_bit = meas_bit && (i_rx_bit != i_exp_bit);
   assign trans_sel = i_detect_trans && !i_combo;
   assign ev_a = trans_sel ? (err_bit && (i_exp_bit != prev_exp_r)) :
      (err_bit && i_rx_bit && !i_exp_bit);
   assign ev_b = trans_sel ? (err_bit && (i_exp_bit == prev_exp_r)) :
      (err_bit && !i_rx_bit && i_exp_bit);

   assign upd_tick = ms_tick_r && (upd_ms_r + 10'h1 >= upd_len);
   assign intv_end = ms_tick_r && (intv_ms_r + 10'h1 >= intv_len);
   assign err_now = intv_err_r || err_bit;

   // Millisecond and second enables; a second is a thousand ms ticks.
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ms_div_r <= 32'h0;
         ms_tick_r <= 1'b0;
         ms_in_s_r <= 10'h0;
         sec_tick_r <= 1'b0;
      end else if (i_start) begin
         ms_div_r <= 32'h0;
         ms_tick_r <= 1'b0;
         ms_in_s_r <= 10'h0;
         sec_tick_r <= 1'b0;
      end else begin
         ms_tick_r <= (ms_div_r == ms_last);
         ms_div_r <= (ms_div_r == ms_last) ? 32'h0 : ms_div_r + 32'h1;
         sec_tick_r <= ms_tick_r && (ms_in_s_r == `EMG_MS_PER_S - 10'h1);
         if (ms_tick_r) begin
            ms_in_s_r <= (ms_in_s_r == `EMG_MS_PER_S - 10'h1) ? 10'h0 :
               ms_in_s_r + 10'h1;
         end
      end
   end

   // Run control and period sequencing.
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_running <= 1'b0;
         o_period_done <= 1'b0;
         sec_cnt_r <= 24'h0;
      end else begin
         o_period_done <= period_end;
         if (i_start) begin
            o_running <= 1'b1;
            sec_cnt_r <= 24'h0;
         end else if (i_stop) begin
            o_running <= 1'b0;
         end else if (period_end) begin
            sec_cnt_r <= 24'h0;
            o_running <= (i_cycle == `EMG_C_REPEAT);
         end else if (o_running && sec_tick_r) begin
            sec_cnt_r <= sec_cnt_r + 24'h1;
         end
      end
   end

   // Event counters; a new period starts them from zero.
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_a_r <= 56'h0;
         cnt_b_r <= 56'h0;
         cnt_clk_r <= 56'h0;
         cnt_blk_r <= 56'h0;
         prev_exp_r <= 1'b0;
      end else if (i_start || period_end) begin
         cnt_a_r <= 56'h0;
         cnt_b_r <= 56'h0;
         cnt_clk_r <= 56'h0;
         cnt_blk_r <= 56'h0;
      end else begin
         if (i_bit_vld) begin
            prev_exp_r <= i_exp_bit;
         end
         if (ev_a) begin
            cnt_a_r <= cnt_a_r + 56'h1;
         end
         if (ev_b) begin
            cnt_b_r <= cnt_b_r + 56'h1;
         end
         if (o_running && i_bit_vld) begin
            cnt_clk_r <= cnt_clk_r + 56'h1;
         end
         if (o_running && i_block_done) begin
            cnt_blk_r <= cnt_blk_r + 56'h1;
         end
      end
   end

   // Errored and error-free intervals; an error on the closing cycle counts.
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         intv_ms_r <= 10'h0;
         intv_err_r <= 1'b0;
         ei_r <= 32'h0;
         efi_r <= 32'h0;
      end else if (i_start || period_end) begin
         intv_ms_r <= 10'h0;
         intv_err_r <= 1'b0;
         ei_r <= 32'h0;
         efi_r <= 32'h0;
      end else if (o_running) begin
         if (intv_end) begin
            intv_ms_r <= 10'h0;
            intv_err_r <= 1'b0;
            if (err_now) begin
               ei_r <= ei_r + 32'h1;
            end else begin
               efi_r <= efi_r + 32'h1;
            end
         end else begin
            intv_err_r <= err_now;
            if (ms_tick_r) begin
               intv_ms_r <= intv_ms_r + 10'h1;
            end
         end
      end
   end

   // Interim update interval counter and immediate-mode snapshots.
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         upd_ms_r <= 10'h0;
         snap_a_r <= 56'h0;
         snap_b_r <= 56'h0;
         snap_clk_r <= 56'h0;
         snap_blk_r <= 56'h0;
      end else if (i_start || period_end) begin
         upd_ms_r <= 10'h0;
         snap_a_r <= 56'h0;
         snap_b_r <= 56'h0;
         snap_clk_r <= 56'h0;
         snap_blk_r <= 56'h0;
      end else if (ms_tick_r) begin
         upd_ms_r <= upd_tick ? 10'h0 : upd_ms_r + 10'h1;
         if (upd_tick) begin
            snap_a_r <= cnt_a_r;
            snap_b_r <= cnt_b_r;
            snap_clk_r <= cnt_clk_r;
            snap_blk_r <= cnt_blk_r;
         end
      end
   end

   // Published results: interim updates while current is on, period totals at every period end.
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result_vld <= 1'b0;
         o_err_total <= 56'h0;
         o_err_a <= 56'h0;
         o_err_b <= 56'h0;
         o_clk_cnt <= 56'h0;
         o_blk_cnt <= 56'h0;
         o_errored_interval_count <= 32'h0;
         o_error_free_interval_count <= 32'h0;
      end else begin
         o_result_vld <= 1'b0;
         if (i_current_on && o_running && upd_tick && !period_end) begin
            o_result_vld <= 1'b1;
            if (i_calc_immediate) begin
               o_err_a <= cnt_a_r - snap_a_r;
               o_err_b <= cnt_b_r - snap_b_r;
               o_err_total <= (cnt_a_r - snap_a_r) + (cnt_b_r - snap_b_r);
               o_clk_cnt <= cnt_clk_r - snap_clk_r;
               o_blk_cnt <= cnt_blk_r - snap_blk_r;
            end else begin
               o_err_a <= cnt_a_r;
               o_err_b <= cnt_b_r;
               o_err_total <= cnt_a_r + cnt_b_r;
               o_clk_cnt <= cnt_clk_r;
               o_blk_cnt <= cnt_blk_r;
            end
            o_errored_interval_count <= ei_r;
            o_error_free_interval_count <= efi_r;
         end else if (period_end) begin
            // Held until the next period closes when current is off.
            o_result_vld <= 1'b1;
            o_err_a <= cnt_a_r;
            o_err_b <= cnt_b_r;
            o_err_total <= cnt_a_r + cnt_b_r;
            o_clk_cnt <= cnt_clk_r;
            o_blk_cnt <= cnt_blk_r;
            o_errored_interval_count <= ei_r;
            o_error_free_interval_count <= efi_r;
         end
      end
   end

   // Block masking state; changes are refused for generated patterns or capture.
   always @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_blk_win_en <= 1'b0;
         o_blk_win_refused <= 1'b0;
         o_trans_mode <= 1'b0;
      end else begin
         o_trans_mode <= trans_sel;
         o_blk_win_refused <= i_blk_win_set && (i_pat_prbs_mixed || i_capturing);
         if (i_blk_win_set && !i_pat_prbs_mixed && !i_capturing) begin
            o_blk_win_en <= i_blk_win_val;
         end
      end
   end

endmodule // emg_gating

// file: emg_eut_model.sv
// Far-end model: a serial source feeding the gating block one bit a clock.
// Assumes the block samples on the rising edge; lines change on the falling one.
`timescale 1ns/1ps
module emg_eut_model (
   input wire i_clk_sys, // System clock.
   input wire i_en, // Send bits while high.
   input wire [1:0] i_fault, // 0 clean, 1 insertion, 2 omission.
   output reg o_bit_vld, // Bit strobe.
   output reg o_rx_bit, // Received bit.
   output reg o_exp_bit, // Expected bit.
   output reg [8:0] o_pat_pos, // Pattern position.
   output reg o_block_done // Block finished pulse.
);
   initial begin
      {o_bit_vld, o_rx_bit, o_exp_bit, o_pat_pos, o_block_done} = 13'h0000;
   end
   // Expected bits alternate; a fault flips only bits of the chosen polarity.
   // Idle lines keep toggling, so a stale bit never looks like a settled one.
   always @(negedge i_clk_sys) begin
      o_bit_vld <= i_en;
      o_block_done <= i_en && o_pat_pos == 9'h1ff;
      if (i_en) begin
         o_pat_pos <= o_pat_pos + 9'h001;
         o_exp_bit <= ~o_exp_bit;
         o_rx_bit <= ~o_exp_bit ^ (i_fault == {~o_exp_bit, o_exp_bit});
      end else begin
         o_rx_bit <= ~o_rx_bit;
         o_exp_bit <= ~o_exp_bit;
      end
   end
endmodule // emg_eut_model

// file: emg_gating_asserts.sv
// Checker for the gating block's control and result ports.
// Assumes it is bound to the block; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`include "emg_consts.vh"
module emg_gating_asserts (
   input wire i_clk_sys, // Clock.
   input wire i_rst_n, // Reset, active low.
   input wire i_start, // Start pulse.
   input wire i_stop, // Stop pulse.
   input wire [1:0] i_cycle, // Cycle mode.
   input wire i_combo, // Combination active.
   input wire i_blk_win_set, // Mask change request.
   input wire i_blk_win_val, // Requested mask state.
   input wire i_pat_prbs_mixed, // Refuse condition.
   input wire i_capturing, // Refuse condition.
   input wire o_running, // Running.
   input wire o_period_done, // Period done.
   input wire o_result_vld, // Results published.
   input wire [55:0] o_err_total, // Total errors.
   input wire [55:0] o_err_a, // First class.
   input wire [55:0] o_err_b, // Second class.
   input wire o_blk_win_en, // Mask state.
   input wire o_blk_win_refused, // Refused pulse.
   input wire o_trans_mode // Transition mode.
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // Run control follows start and stop one edge later.
   a_start_runs: assert property (i_start |=> o_running)
      else $error("start did not run");
   a_stop_halts: assert property (i_stop && !i_start |=> !o_running)
      else $error("stop did not halt");
   a_untimed_open: assert property ($past(i_cycle) == `EMG_C_UNTIMED |-> !o_period_done)
      else $error("untimed period ended");
   a_single_stop: assert property (o_period_done && i_cycle == `EMG_C_SINGLE &&
      !$past(i_start) |-> !o_running) else $error("single kept running");
   a_repeat_runs: assert property (o_period_done && i_cycle == `EMG_C_REPEAT &&
      !$past(i_stop) |-> o_running) else $error("repeat stopped");
   // Published totals are consistent and held between publications.
   a_total_sum: assert property (o_result_vld |-> o_err_total == o_err_a + o_err_b)
      else $error("total not the sum");
   a_done_pub: assert property (o_period_done |-> o_result_vld)
      else $error("period end not published");
   a_result_held: assert property (!o_result_vld && !$past(i_start) |->
      $stable(o_err_total)) else $error("total moved without publish");
   // Mask changes are taken or refused by the pattern and capture state.
   a_mask_refuse: assert property (i_blk_win_set && (i_pat_prbs_mixed || i_capturing)
      |=> o_blk_win_refused && $stable(o_blk_win_en)) else $error("mask change not refused");
   a_mask_take: assert property (i_blk_win_set && !i_pat_prbs_mixed && !i_capturing
      |=> o_blk_win_en == $past(i_blk_win_val) && !o_blk_win_refused)
      else $error("mask change not taken");
   a_combo_trans: assert property ($past(i_combo) |-> !o_trans_mode)
      else $error("transition mode under combination");
endmodule // emg_gating_asserts

// file: emg_gating_tb.sv
// Testbench for the gating block with a far-end bit source model.
// Assumes a shortened millisecond of 4 clocks, so one second is 4000 clocks.
`timescale 1ns/1ps
`include "emg_consts.vh"
module emg_gating_tb;
   localparam int SEC = 4000;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg start = 1'b0, stop = 1'b0, en = 1'b0, cur = 1'b0, imm = 1'b0, combo = 1'b0;
   reg trans = 1'b0, bset = 1'b0, bval = 1'b0, prbs = 1'b0, cap = 1'b0, bwen = 1'b0;
   reg [1:0] unit = 2'h0, cyc = 2'h1, upd = 2'h0, intv = 2'h0, fault = 2'h0;
   reg [23:0] per = 24'h000001;
   reg [4:0] texp = 5'h04;
   reg [15:0] bmap = 16'hffff;
   wire vld, rx, ex, bdone, run, done, rv, ben, bref, tm;
   wire [8:0] pos;
   wire [55:0] tot, ea, eb, cc, bc;
   wire [31:0] ei, error_free_interval_count;
   int err_total = 0;
   int comparisons = 0;
   int cyc_n = 0;
   int t0 = 0;
   emg_eut_model emg_eut_model_i (.i_clk_sys(clk), .i_en(en), .i_fault(fault),
      .o_bit_vld(vld), .o_rx_bit(rx), .o_exp_bit(ex), .o_pat_pos(pos), .o_block_done(bdone));
   // The mask bit follows the expected bit, so masking hides omission faults only.
   emg_gating #(.MS_CYCLES(4)) emg_gating_i (.i_clk_sys(clk), .i_rst_n(rst_n),
      .i_start(start), .i_stop(stop), .i_unit(unit), .i_cycle(cyc), .i_period_s(per),
      .i_target_exp(texp), .i_current_on(cur), .i_calc_immediate(imm), .i_upd_sel(upd),
      .i_combo(combo), .i_detect_trans(trans), .i_intv_sel(intv), .i_bit_vld(vld),
      .i_rx_bit(rx), .i_exp_bit(ex), .i_pat_pos(pos), .i_mask_bit(ex), .i_block_done(bdone),
      .i_blk_win_set(bset), .i_blk_win_val(bval), .i_pat_prbs_mixed(prbs),
      .i_capturing(cap), .i_bit_win_en(bwen), .i_bit_win_map(bmap), .o_running(run),
      .o_period_done(done), .o_result_vld(rv), .o_err_total(tot), .o_err_a(ea),
      .o_err_b(eb), .o_clk_cnt(cc), .o_blk_cnt(bc), .o_errored_interval_count(ei),
      .o_error_free_interval_count(error_free_interval_count), .o_blk_win_en(ben), .o_blk_win_refused(bref),
      .o_trans_mode(tm));
   // Free-running 50 MHz clock.
   initial begin
      forever #10 clk = ~clk;
   end
   // Edge count for timing checks; a hung run is cut short here.
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 80000) begin
         err_total++;
         conclude;
      end
   end
   task automatic check(input logic [55:0] seen, input logic [55:0] want);
      comparisons++;
      if (seen !== want) begin
         err_total++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Source enable goes by non-blocking write, since the model also acts on this edge.
   // A clock passes first, so an enable lowered by the last test is not raised at once.
   task automatic go;
      tick(1);
      start = 1'b1;
      en <= 1'b1;
      tick(1);
      start = 1'b0;
      t0 = cyc_n;
   endtask
   // Waits a bounded time for a publish (sel high) or a period end; gives clocks since start.
   task automatic wait_for(input bit sel, output int dt);
      int k;
      k = 0;
      while ((sel ? rv : done) !== 1'b1 && k < 30000) begin
         tick(1);
         k++;
      end
      dt = cyc_n - t0;
   endtask
   // Spacing of two publications, skipping the first after a setting change.
   task automatic gap(output int s);
      int d;
      wait_for(1'b1, d);
      tick(1);
      wait_for(1'b1, d);
      s = cyc_n;
      tick(1);
      wait_for(1'b1, d);
      s = cyc_n - s;
   endtask
   task automatic t_single;
      int dt;
      fault <= 2'h1;
      go;
      wait_for(1'b0, dt);
      check(dt inside {[SEC - 5:SEC + 10]}, 1);
      check(eb, 0);
      check(ea > cc / 3 && ea < cc, 1);
      check(ei inside {[995:1001]}, 1);
      check(error_free_interval_count, 0);
      tick(3);
      check(run, 0);
      en <= 1'b0;
      $display("single period test ended");
   endtask
   task automatic t_omit;
      int dt;
      fault <= 2'h2;
      go;
      wait_for(1'b0, dt);
      check(ea, 0);
      check(eb > 0, 1);
      en <= 1'b0;
      bset = 1'b1;
      bval = 1'b1;
      tick(1);
      bset = 1'b0;
      check(ben, 1);
      cyc = `EMG_C_REPEAT;
      go;
      wait_for(1'b0, dt);
      tick(1);
      wait_for(1'b0, dt);
      check(dt inside {[2 * SEC - 5:2 * SEC + 10]}, 1);
      check(tot, 0);
      check(run, 1);
      // The request stands over both refused edges and the accepted one.
      bset = 1'b1;
      bval = 1'b0;
      for (int i = 0; i < 2; i++) begin
         {prbs, cap} = 2'h1 << i;
         tick(1);
         check(bref, 1);
         check(ben, 1);
      end
      {prbs, cap} = 2'h0;
      stop = 1'b1;
      tick(1);
      {bset, stop} = 2'h0;
      en <= 1'b0;
      check(ben, 0);
      check(run, 0);
      $display("omission and masking test ended");
   endtask
   task automatic t_clkcnt;
      int dt;
      unit = `EMG_U_CLK;
      cyc = `EMG_C_SINGLE;
      intv = `EMG_I_1S;
      bwen = 1'b1;
      bmap = 16'h0000;
      fault <= 2'h1;
      go;
      wait_for(1'b0, dt);
      check(dt inside {[3 * SEC - 5:3 * SEC + 10]}, 1);
      check(cc >= 56'd10000, 1);
      check(tot, 0);
      check(error_free_interval_count inside {[2:3]}, 1);
      check(bc inside {[22:24]}, 1);
      en <= 1'b0;
      bwen = 1'b0;
      $display("clock count test ended");
   endtask
   // Error-count gating: half the bits are inserted errors, so E+4 takes five seconds.
   task automatic t_errcnt;
      int dt;
      unit = `EMG_U_ERR;
      go;
      wait_for(1'b0, dt);
      check(dt inside {[5 * SEC - 5:5 * SEC + 10]}, 1);
      check(tot >= 56'd10000, 1);
      check(tot, ea + eb);
      check(eb, 0);
      en <= 1'b0;
      $display("error count test ended");
   endtask
   task automatic t_interim;
      int s;
      int sp[4] = '{400, 400, 800, 2000};
      cyc = `EMG_C_UNTIMED;
      cur = 1'b1;
      go;
      for (int m = 0; m < 4; m++) begin
         imm = m > 0;
         upd = m > 1 ? `EMG_UPD_500 : `EMG_UPD_100;
         combo = m == 3;
         gap(s);
         check(s, sp[m]);
         check(m ? tot inside {[sp[m] / 2 - 5:sp[m] / 2 + 5]} : tot > 56'd400, 1);
      end
      trans = 1'b1;
      tick(2);
      check(tm, 0);
      combo = 1'b0;
      tick(2);
      check(tm, 1);
      // Alternating expected bits make every measured bit a transition bit.
      wait_for(1'b1, s);
      tick(1);
      wait_for(1'b1, s);
      check(eb, 0);
      check(ea inside {[395:405]}, 1);
      check(run, 1);
      stop = 1'b1;
      tick(1);
      stop = 1'b0;
      tick(1);
      check(run, 0);
      $display("interim results test ended");
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Reset for four clocks, then the scenarios in turn.
   initial begin
      tick(4);
      rst_n = 1'b1;
      tick(1);
      check(run, 0);
      check(tot, 0);
      t_single;
      t_omit;
      t_clkcnt;
      t_errcnt;
      t_interim;
      conclude;
   end
endmodule // emg_gating_tb
bind emg_gating emg_gating_asserts emg_gating_asserts_i (.*);
